//--- ffd_field_mem.sv
// two-field serial memory with pointer clears and old/new field choice
`timescale 1ns/10ps
module ffd_field_mem
  import ffd_pkg::*;
(
  // clock and reset
  input  wire logic                        sys_clk,
  input  wire logic                        rstn,
  // write port pins
  input  wire logic                        wr_shift_clock,
  input  wire logic                        wr_pointer_clear,
  input  wire logic                        wrEnable,
  input  wire logic                        input_mask,
  input  wire logic [ffd_pkg::DATA_W-1:0]  dataIn,
  // read port pins
  input  wire logic                        rd_shift_clock,
  input  wire logic                        rd_pointer_clear,
  input  wire logic                        fetch_advance_gate,
  input  wire logic                        outputGate,
  // data output pins, enable active low
  output logic [ffd_pkg::DATA_W-1:0]       dataOut,
  output logic                             dataOutOen,
  // status
  output logic                             wrReady,
  output logic                             ptrValid
);
  import ffd_pkg::*;

  ffd_wr_pins_t      wrMeta, wrSync, wrLast;
  ffd_rd_pins_t      rdMeta, rdSync, rdLast;
  ffd_wr_word_t      pushWord, popWord;
  logic [DATA_W-1:0] fieldMem [0:(2**(ADDR_W+1))-1];
  logic [ADDR_W-1:0] wrAddr, rdAddr;
  logic [AGE_W-1:0]  wrAge;
  logic [DUMMY_W-1:0] wrDummy, rdDummy;
  logic              wrBank, rdBank, outEn, wrInit, rdInit;
  logic              wrEdge, rdEdge, wrClr, rdClr, rdFetch;
  logic              pushValid, popValid, popReady;

  // two-stage pin synchronisers plus one stage for edge finding
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wrMeta <= '0;
      wrSync <= '0;
      wrLast <= '0;
      rdMeta <= '0;
      rdSync <= '0;
      rdLast <= '0;
    end else begin
      wrMeta <= {wr_shift_clock, wr_pointer_clear, wrEnable, input_mask,
                 dataIn};
      wrSync <= wrMeta;
      wrLast <= wrSync;
      rdMeta <= {rd_shift_clock, rd_pointer_clear, fetch_advance_gate,
                 outputGate};
      rdSync <= rdMeta;
      rdLast <= rdSync;
    end
  end

  // edge strobes and decoded cycle kinds
  assign wrEdge  = wrSync.clk & ~wrLast.clk;
  assign rdEdge  = rdSync.clk & ~rdLast.clk;
  assign wrClr   = wrEdge & wrSync.clear;
  assign rdClr   = rdEdge & rdSync.clear;
  assign rdFetch = rdEdge & ~rdSync.clear & rdSync.advance;

  // write address counter
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wrAddr <= ADDR_ZERO;
    end else if (wrClr) begin
      wrAddr <= ADDR_ZERO;
    end else if (wrEdge && wrSync.enable) begin
      wrAddr <= wrAddr + 1'b1;
    end
  end

  // field bank flip and age of the current field in write cycles
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wrBank <= 1'b0;
      wrAge  <= AGE_ZERO;
    end else if (wrClr) begin
      wrBank <= ~wrBank;
      wrAge  <= AGE_ZERO;
    end else if (wrEdge && wrAge != AGE_MAX) begin
      wrAge <= wrAge + 1'b1;
    end
  end

  // masked writes queue up behind read fetches
  assign pushValid = wrEdge & ~wrSync.clear & wrSync.enable & wrSync.mask;
  assign pushWord  = '{bank: wrBank, addr: wrAddr, data: wrSync.data};
  assign popReady  = ~rdFetch;

  ffd_fifo #(
    .WIDTH ($bits(ffd_wr_word_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk  (sys_clk),
    .rstn     (rstn),
    .inValid  (pushValid),
    .inReady  (wrReady),
    .inData   (pushWord),
    .outValid (popValid),
    .outReady (popReady),
    .outData  (popWord)
  );

  // array write from the queue
  always_ff @(posedge sys_clk) begin
    if (popValid && popReady) begin
      fieldMem[{popWord.bank, popWord.addr}] <= popWord.data;
    end
  end

  // read address counter, gate-independent of the output gate
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rdAddr <= ADDR_ZERO;
    end else if (rdClr) begin
      rdAddr <= ADDR_ZERO;
    end else if (rdFetch) begin
      rdAddr <= rdAddr + 1'b1;
    end
  end

  // field choice at read clear: young write field means old data
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rdBank <= 1'b0;
    end else if (rdClr) begin
      rdBank <= (wrAge < OLD_LIMIT) ? ~wrBank : wrBank;
    end
  end

  // output data register
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      dataOut <= DATA_ZERO;
    end else if (rdFetch) begin
      dataOut <= fieldMem[{rdBank, rdAddr}];
    end
  end

  // output gate sampled on read edges only
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      outEn <= 1'b0;
    end else if (rdEdge) begin
      outEn <= rdSync.outGate;
    end
  end

  assign dataOutOen = ~outEn;

  // dummy cycle counters and initialisation tracking
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wrDummy <= DUMMY_ZERO;
      rdDummy <= DUMMY_ZERO;
      wrInit  <= 1'b0;
      rdInit  <= 1'b0;
    end else begin
      if (wrEdge && wrDummy != DUMMY_MIN) begin
        wrDummy <= wrDummy + 1'b1;
      end
      if (rdEdge && rdDummy != DUMMY_MIN) begin
        rdDummy <= rdDummy + 1'b1;
      end
      if (wrClr && wrDummy == DUMMY_MIN) begin
        wrInit <= 1'b1;
      end
      if (rdClr && rdDummy == DUMMY_MIN) begin
        rdInit <= 1'b1;
      end
    end
  end

  assign ptrValid = wrInit & rdInit;

  a_gate_sampled: assert property (@(posedge sys_clk)
    disable iff (!rstn) rdEdge |=> dataOutOen == !$past(rdSync.outGate))
    else $error("output enable does not follow sampled gate");
  a_drive_only_gated: assert property (@(posedge sys_clk)
    disable iff (!rstn) !rdEdge |=> $stable(dataOutOen))
    else $error("output drive changed without read edge");
  a_read_ungated: assert property (@(posedge sys_clk)
    disable iff (!rstn)
    (rdEdge && !rdSync.clear && rdSync.advance)
    |=> rdAddr == $past(rdAddr) + 1'b1)
    else $error("read pointer missed an advance");
  a_read_hold: assert property (@(posedge sys_clk) disable iff (!rstn)
    (rdEdge && !rdSync.clear && !rdSync.advance) |=> $stable(rdAddr))
    else $error("read pointer moved with advance gate low");
  a_read_clear: assert property (@(posedge sys_clk)
    disable iff (!rstn) rdClr |=> rdAddr == ADDR_ZERO)
    else $error("read clear did not zero address");
  a_write_clear: assert property (@(posedge sys_clk)
    disable iff (!rstn) wrClr |=> wrAddr == ADDR_ZERO)
    else $error("write clear did not zero address");
  a_old_field: assert property (@(posedge sys_clk) disable iff (!rstn)
    (rdClr && !wrClr && wrAge < OLD_LIMIT) |=> rdBank != wrBank)
    else $error("young write field not read as old data");
  a_new_field: assert property (@(posedge sys_clk) disable iff (!rstn)
    (rdClr && !wrClr && wrAge >= NEW_LIMIT) |=> rdBank == wrBank)
    else $error("settled write field not read as new data");
  a_init_valid: assert property (@(posedge sys_clk) disable iff (!rstn)
    ptrValid |-> (wrDummy == DUMMY_MIN && rdDummy == DUMMY_MIN))
    else $error("pointers valid before dummy cycles");
  a_gate_low_keeps: assert property (@(posedge sys_clk)
    disable iff (!rstn)
    (rdEdge && !rdSync.outGate && !rdSync.clear && !rdSync.advance)
    |=> ($stable(rdAddr) && dataOutOen))
    else $error("low output gate disturbed pointer or drive");
endmodule

//--- ffd_pkg.sv
// shared constants and carrier types for the field memory
package ffd_pkg;
  localparam int            DATA_W     = 8;
  localparam int            ADDR_W     = 18;
  localparam int            FIFO_DEPTH = 16;
  localparam int            AGE_W      = 10;
  localparam int            DUMMY_W    = 7;
  localparam logic [ADDR_W-1:0]  ADDR_ZERO  = 18'h00000;
  localparam logic [AGE_W-1:0]   AGE_ZERO   = 10'h000;
  localparam logic [AGE_W-1:0]   AGE_MAX    = 10'h3ff;
  localparam logic [AGE_W-1:0]   OLD_LIMIT  = 10'h046; // 70 write cycles
  localparam logic [AGE_W-1:0]   NEW_LIMIT  = 10'h258; // 600 cycles
  localparam logic [DUMMY_W-1:0] DUMMY_ZERO = 7'h00;
  localparam logic [DUMMY_W-1:0] DUMMY_MIN  = 7'h50;   // 80 dummy cycles
  localparam logic [DATA_W-1:0]  DATA_ZERO  = 8'h00;
  // supply settle time the controller must wait, in microseconds
  localparam int            SETTLE_US  = 100;

  // write port pins as sampled
  typedef struct packed {
    logic              clk;
    logic              clear;
    logic              enable;
    logic              mask;
    logic [DATA_W-1:0] data;
  } ffd_wr_pins_t;

  // read port pins as sampled
  typedef struct packed {
    logic clk;
    logic clear;
    logic advance;
    logic outGate;
  } ffd_rd_pins_t;

  // one pending write on its way into the array
  typedef struct packed {
    logic              bank;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } ffd_wr_word_t;
endpackage

//--- ffd_fifo.sv
// small parameterised fifo with valid/ready on both sides
`timescale 1ns/10ps
module ffd_fifo #(
  parameter int WIDTH = 27,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rstn,
  // fill side
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // drain side
  output logic                  outValid,
  input  wire logic             outReady,
  output logic [WIDTH-1:0]      outData
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] store [0:DEPTH-1];
  logic [PW:0]      wrPtr;
  logic [PW:0]      rdPtr;
  logic             push;
  logic             pop;

  // honest full and empty from the pointer pair
  assign inReady  = (wrPtr - rdPtr) != (PW+1)'(DEPTH);
  assign outValid = wrPtr != rdPtr;
  assign outData  = store[rdPtr[PW-1:0]];
  assign push     = inValid & inReady;
  assign pop      = outValid & outReady;

  // storage write
  always_ff @(posedge sys_clk) begin
    if (push) begin
      store[wrPtr[PW-1:0]] <= inData;
    end
  end

  // pointers
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wrPtr <= '0;
      rdPtr <= '0;
    end else begin
      if (push) begin
        wrPtr <= wrPtr + 1'b1;
      end
      if (pop) begin
        rdPtr <= rdPtr + 1'b1;
      end
    end
  end
endmodule

//--- ffd_ctl_model.sv
// controller model driving the write and read pins of the field memory
`timescale 1ns/10ps
module ffd_ctl_model
  import ffd_pkg::*;
(
  // clock
  input  wire logic                 sys_clk,
  // write pins
  output logic                      wrClk,
  output logic                      wrClr,
  output logic                      wrEn,
  output logic                      wrMask,
  output logic [ffd_pkg::DATA_W-1:0] wrData,
  // read pins
  output logic                      rdClk,
  output logic                      rdClr,
  output logic                      rdAdv,
  output logic                      rdGate
);
  // system cycles in one microsecond at 100 MHz
  localparam int CYC_PER_US = 100;

  // all pins idle at time zero
  initial begin
    {wrClk, wrClr, wrEn, wrMask, rdClk, rdClr, rdAdv, rdGate} = 8'h00;
    wrData = DATA_ZERO;
  end

  // one write cycle, four system cycles per phase
  task automatic wr_cyc(input logic clr, en, msk,
                        input logic [DATA_W-1:0] d);
    @(negedge sys_clk);
    {wrClr, wrEn, wrMask} = {clr, en, msk};
    wrData = en ? d : ~wrData; // unused data lines keep moving
    repeat (4) @(negedge sys_clk);
    wrClk = 1'b1;
    repeat (4) @(negedge sys_clk);
    wrClk = 1'b0;
  endtask

  // read pins set up while the read clock is low
  task automatic rd_set(input logic clr, adv, gate);
    @(negedge sys_clk);
    {rdClr, rdAdv, rdGate} = {clr, adv, gate};
  endtask

  // read clock pulse, pins held through the high phase
  task automatic rd_pulse();
    repeat (4) @(negedge sys_clk);
    rdClk = 1'b1;
    repeat (5) @(negedge sys_clk);
    rdClk = 1'b0;
  endtask

  // one full read cycle
  task automatic rd_cyc(input logic clr, adv, gate);
    rd_set(clr, adv, gate);
    rd_pulse();
  endtask

  // settle wait, then dummy cycles on both ports at once
  task automatic dummies();
    repeat (SETTLE_US * CYC_PER_US) @(negedge sys_clk);
    fork
      repeat (DUMMY_MIN) wr_cyc(1'b0, 1'b1, 1'b0, DATA_ZERO);
      repeat (DUMMY_MIN) rd_cyc(1'b0, 1'b1, 1'b0);
    join
  endtask

  // late-settle recovery: clear, dummy cycles, clear on each port
  task automatic reinit();
    fork
      begin
        wr_cyc(1'b1, 1'b0, 1'b0, DATA_ZERO);
        repeat (DUMMY_MIN) wr_cyc(1'b0, 1'b1, 1'b0, DATA_ZERO);
        wr_cyc(1'b1, 1'b0, 1'b0, DATA_ZERO);
      end
      begin
        rd_cyc(1'b1, 1'b0, 1'b0);
        repeat (DUMMY_MIN) rd_cyc(1'b0, 1'b1, 1'b0);
        rd_cyc(1'b1, 1'b0, 1'b0);
      end
    join
  endtask
endmodule

//--- testbench.sv
// self-checking bench for the field memory
`timescale 1ns/10ps
module testbench;
  import ffd_pkg::*;
  logic              sys_clk;
  logic              rstn;
  logic              wrClk, wrClr, wrEn, wrMask;
  logic              rdClk, rdClr, rdAdv, rdGate;
  logic [DATA_W-1:0] wrData;
  logic [DATA_W-1:0] dataOut;
  logic              dataOutOen, wrReady, ptrValid;
  logic [DATA_W-1:0] fieldA [0:639];
  logic [DATA_W-1:0] held;
  int                err_total, cmp_count, nB, i;

  ffd_field_mem ffd_field_mem_i (.sys_clk(sys_clk), .rstn(rstn),
    .wr_shift_clock(wrClk), .wr_pointer_clear(wrClr), .wrEnable(wrEn),
    .input_mask(wrMask), .dataIn(wrData), .rd_shift_clock(rdClk),
    .rd_pointer_clear(rdClr), .fetch_advance_gate(rdAdv),
    .outputGate(rdGate), .dataOut(dataOut), .dataOutOen(dataOutOen),
    .wrReady(wrReady), .ptrValid(ptrValid));

  ffd_ctl_model ffd_ctl_model_i (.sys_clk(sys_clk), .wrClk(wrClk),
    .wrClr(wrClr), .wrEn(wrEn), .wrMask(wrMask), .wrData(wrData),
    .rdClk(rdClk), .rdClr(rdClr), .rdAdv(rdAdv), .rdGate(rdGate));

  // system clock, 10 ns period
  always #5 sys_clk = ~sys_clk;

  // expected byte of the first field
  function automatic logic [DATA_W-1:0] exp_a(input int idx);
    return fieldA[idx];
  endfunction

  // compare and count
  task automatic check(input string name,
                       input logic [DATA_W-1:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // verdict and end of run
  task automatic final_report();
    if (err_total == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // watchdog about twice the expected 20000-cycle run
  initial begin
    #400000;
    err_total++;
    final_report();
  end

  // main sequence
  initial begin
    sys_clk = 1'b0;
    rstn = 1'b0;
    err_total = 0;
    cmp_count = 0;
    void'($urandom(46063));
    repeat (12) @(posedge sys_clk);
    check("oen", 8'(dataOutOen), 8'h01);
    check("valid", 8'(ptrValid), 8'h00);
    check("ready", 8'(wrReady), 8'h01);
    @(negedge sys_clk);
    rstn = 1'b1;
    ffd_ctl_model_i.dummies();
    check("valid", 8'(ptrValid), 8'h00);
    fork
      ffd_ctl_model_i.wr_cyc(1'b1, 1'b0, 1'b0, 8'h00);
      ffd_ctl_model_i.rd_cyc(1'b1, 1'b0, 1'b0);
    join
    repeat (6) @(negedge sys_clk);
    check("valid", 8'(ptrValid), 8'h01);
    // second clear sequence on both ports keeps pointers valid
    ffd_ctl_model_i.reinit();
    check("revalid", 8'(ptrValid), 8'h01);
    // first field, long enough for new data
    ffd_ctl_model_i.wr_cyc(1'b1, 1'b0, 1'b1, 8'h00);
    for (i = 0; i < 640; i++) begin
      fieldA[i] = 8'($urandom);
      ffd_ctl_model_i.wr_cyc(1'b0, 1'b1, 1'b1, fieldA[i]);
    end
    ffd_ctl_model_i.rd_cyc(1'b1, 1'b0, 1'b0);
    for (i = 0; i < 8; i++) begin
      ffd_ctl_model_i.rd_cyc(1'b0, 1'b1, 1'b1);
      check("new", dataOut, exp_a(i));
      check("oen", 8'(dataOutOen), 8'h00);
    end
    // advance gate low holds the pointer
    held = dataOut;
    ffd_ctl_model_i.rd_cyc(1'b0, 1'b0, 1'b1);
    check("hold", dataOut, held);
    ffd_ctl_model_i.rd_cyc(1'b0, 1'b1, 1'b1);
    check("next", dataOut, exp_a(8));
    // output gate low skips a byte
    ffd_ctl_model_i.rd_set(1'b0, 1'b1, 1'b0);
    repeat (2) @(negedge sys_clk);
    check("oen", 8'(dataOutOen), 8'h00);
    ffd_ctl_model_i.rd_pulse();
    check("oen", 8'(dataOutOen), 8'h01);
    ffd_ctl_model_i.rd_cyc(1'b0, 1'b1, 1'b1);
    check("skip", dataOut, exp_a(10));
    // second field begun, read clear soon after
    ffd_ctl_model_i.wr_cyc(1'b1, 1'b0, 1'b1, 8'h00);
    nB = 5 + $urandom_range(55);
    repeat (nB) begin
      ffd_ctl_model_i.wr_cyc(1'b0, 1'b1, 1'($urandom_range(1)),
                             8'($urandom));
    end
    ffd_ctl_model_i.rd_cyc(1'b1, 1'b0, 1'b0);
    for (i = 0; i < 8; i++) begin
      ffd_ctl_model_i.rd_cyc(1'b0, 1'b1, 1'b1);
      check("old", dataOut, exp_a(i));
    end
    final_report();
  end
endmodule
